// *** rtl/wsr_map.svh ***
// Offsets, field positions, reset values and counts of the status responder
`ifndef WSR_MAP_SVH
`define WSR_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define WSR_REG_CTRL 8'h00
`define WSR_REG_STATUS 8'h04
`define WSR_REG_TXPWR 8'h08
`define WSR_REG_PWR 8'h0c
`define WSR_REG_RUNTIME 8'h10
`define WSR_REG_NAMELEN 8'h14
`define WSR_STORE_BASE 8'h40
`define WSR_STORE_LAST 8'h8c
`define WSR_STORE_WORDS 20

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WSR_CTRL_RST 4'h2
`define WSR_TXPWR_RST 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WSR_CTRL_WAKE 0
`define WSR_CTRL_SELF 1
`define WSR_CTRL_RECH 2
`define WSR_CTRL_CHG 3
`define WSR_FEAT_PN_BIT 4

// ----------------------------------------------------------------
// Request coding and response lengths
// ----------------------------------------------------------------
`define WSR_REQ_TYPE_IN 8'h80
`define WSR_GET_STATUS 8'h00
`define WSR_FEAT_POWER_IND 8'h04
`define WSR_LEN_STD 7'h02
`define WSR_LEN_FEAT 7'h01
`define WSR_LEN_CHAN 7'h01
`define WSR_LEN_TXP 7'h02
`define WSR_LEN_PWR 7'h06
`define WSR_ID_BYTES 7'h10
`define WSR_NAME_MAX 7'h40

`endif

// *** rtl/wsr_pkg.sv ***
// Types shared by the status responder files
package wsr_pkg;

  typedef enum logic [2:0] {
    SEL_STD = 3'h0,
    SEL_FEAT = 3'h1,
    SEL_CHAN = 3'h2,
    SEL_RSV3 = 3'h3,
    SEL_RSV4 = 3'h4,
    SEL_TXP = 3'h5,
    SEL_PWR = 3'h6,
    SEL_HOST = 3'h7
  } wsr_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1
  } wsr_state_t;

  typedef struct packed {
    logic [7:0] req_type;
    logic [7:0] request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } wsr_setup_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } wsr_apb_req_t;

endpackage : wsr_pkg

// *** rtl/wsr_pin_sync.sv ***
// Three-stage synchroniser that accepts a change once stages two and three agree
module wsr_pin_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level_out
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      level_out <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_out <= s3_ff;
    end
  end

endmodule : wsr_pin_sync

// *** rtl/wsr_host_store.sv ***
// Word store for the other host's identity key and display name
`include "wsr_map.svh"
module wsr_host_store (
  // Clock
  input wire logic clk_in,
  // Word write port
  input wire logic we_in,
  input wire logic [4:0] waddr_in,
  input wire logic [31:0] wdata_in,
  // Word read port
  input wire logic [4:0] raddr_in,
  output logic [31:0] rword_out,
  // Byte read port, little-endian within a word
  input wire logic [6:0] rbyte_addr_in,
  output logic [7:0] rbyte_out
);

  logic [31:0] mem [`WSR_STORE_WORDS];
  logic [31:0] bword;

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  assign rword_out = mem[raddr_in];
  assign bword = mem[rbyte_addr_in[6:2]];
  assign rbyte_out = bword[{rbyte_addr_in[1:0], 3'b000} +: 8];

endmodule : wsr_host_store

// *** rtl/wsr_responder.sv ***
// Extended status request responder with APB register file
//
// Our own choices: the address map and the APB interface to the registers.
`include "wsr_map.svh"
// Summary of operation
// - Standard status returns two bytes, self-powered in D0, wake in D1.
// - The self-powered flag is reported as one unless software changes it.
// - Bit D2 of the standard status byte shows battery supply.
// - Feature requests never alter the battery indication.
// - Feature status returns one byte with power notice enable in D4.
// - All feature flags clear at power-up and at every device reset.
// - Feature set enables power notices, feature clear disables them.
// - Channel info returns the link quality of the last management packet.
// - Transmit power returns notice power steps and a reserved zero byte.
// - Power status returns percent available then 16-bit run time.
// - Power status bytes 3 and 4 hold warning and critical percentages.
// - Power status byte 5 is the charge bitmap with bits 7:2 zero.
// - Other-host status starts with the 16-byte host identity key.
// - The display name follows at offset 16, 0000H to 0040H long.
// - wIndex picks the response; encodings 3 and 4 are reserved.
module wsr_responder
  import wsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // APB slave
  input wire wsr_apb_req_t apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Setup packet of a status request
  input wire logic setup_valid_in,
  input wire wsr_setup_t setup_in,
  // Data stage byte stream
  input wire logic rsp_ready_in,
  output logic rsp_valid_out,
  output logic [7:0] rsp_byte_out,
  output logic rsp_last_out,
  output logic stall_out,
  // Feature requests
  input wire logic feat_set_in,
  input wire logic feat_clr_in,
  input wire logic [7:0] feat_sel_in,
  output logic power_notice_en_out,
  // Link quality of received management packets
  input wire logic lq_valid_in,
  input wire logic [7:0] link_quality_value_in,
  // Supply sense pin
  input wire logic battery_pin_in
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0] ctrl_ff;
  logic [7:0] notice_tx_power_steps_ff;
  logic [7:0] available_power_percent_ff;
  logic [7:0] warning_power_percent_ff;
  logic [7:0] critical_power_percent_ff;
  logic [15:0] remaining_run_time_ff;
  logic [6:0] name_len_ff;
  logic [7:0] link_quality_value_ff;
  logic battery_lvl;
  wsr_state_t state_ff;
  wsr_sel_t sel_ff;
  logic [6:0] cnt_ff;
  logic [6:0] idx_ff;
  logic [6:0] pos_ff;
  logic [7:0] charge_state_bitmap;
  logic [7:0] store_byte;
  logic [31:0] store_word;
  logic [7:0] nxt_byte;
  logic [6:0] resp_len;
  logic [31:0] rd_data;
  logic rd_hit;
  logic store_hit;
  logic [7:0] store_off;
  logic apb_setup;
  logic apb_wr;
  logic req_legal;

  assign apb_setup = apb_in.psel & ~apb_in.penable;
  assign apb_wr = apb_in.psel & apb_in.penable & pready_out & apb_in.pwrite;
  assign store_off = apb_in.paddr - `WSR_STORE_BASE;
  assign store_hit = (apb_in.paddr >= `WSR_STORE_BASE) &&
                     (apb_in.paddr <= `WSR_STORE_LAST);

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Pin sense is asynchronous; a glitch must not reach a reply byte
  wsr_pin_sync u_batt (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pin_in(battery_pin_in),
    .level_out(battery_lvl)
  );

  wsr_host_store u_store (
    .clk_in(clk_in),
    .we_in(apb_wr & store_hit),
    .waddr_in(store_off[6:2]),
    .wdata_in(apb_in.pwdata),
    .raddr_in(store_off[6:2]),
    .rword_out(store_word),
    .rbyte_addr_in(idx_ff),
    .rbyte_out(store_byte)
  );

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0;
    case (apb_in.paddr)
      `WSR_REG_CTRL: rd_data = {28'h0, ctrl_ff};
      `WSR_REG_STATUS: begin
        rd_data = {16'h0, link_quality_value_ff, 6'h0,
                   power_notice_en_out, battery_lvl};
      end
      `WSR_REG_TXPWR: rd_data = {24'h0, notice_tx_power_steps_ff};
      `WSR_REG_PWR: begin
        rd_data = {8'h0, critical_power_percent_ff,
                   warning_power_percent_ff, available_power_percent_ff};
      end
      `WSR_REG_RUNTIME: rd_data = {16'h0, remaining_run_time_ff};
      `WSR_REG_NAMELEN: rd_data = {25'h0, name_len_ff};
      default: begin
        rd_hit = store_hit;
        rd_data = store_hit ? store_word : 32'h0;
      end
    endcase
  end

  // Zero wait state: the answer is registered in the setup cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else begin
      pready_out <= apb_setup;
      pslverr_out <= apb_setup & ~rd_hit;
      prdata_out <= (apb_setup && !apb_in.pwrite) ? rd_data : 32'h0;
    end
  end

  // Self-powered resets to one since the device counts as self-powered
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_ff <= `WSR_CTRL_RST;
      notice_tx_power_steps_ff <= `WSR_TXPWR_RST;
      available_power_percent_ff <= 8'h00;
      warning_power_percent_ff <= 8'h00;
      critical_power_percent_ff <= 8'h00;
      remaining_run_time_ff <= 16'h0000;
      name_len_ff <= 7'h00;
    end else if (apb_wr) begin
      case (apb_in.paddr)
        `WSR_REG_CTRL: ctrl_ff <= apb_in.pwdata[3:0];
        `WSR_REG_TXPWR: notice_tx_power_steps_ff <= apb_in.pwdata[7:0];
        `WSR_REG_PWR: begin
          available_power_percent_ff <= apb_in.pwdata[7:0];
          warning_power_percent_ff <= apb_in.pwdata[15:8];
          critical_power_percent_ff <= apb_in.pwdata[23:16];
        end
        `WSR_REG_RUNTIME: remaining_run_time_ff <= apb_in.pwdata[15:0];
        `WSR_REG_NAMELEN: begin
          // Longer names are clipped to the largest legal length
          name_len_ff <= (apb_in.pwdata[31:0] > 32'h40) ?
                         `WSR_NAME_MAX : apb_in.pwdata[6:0];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Features and link quality
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle; battery bit is not touched
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      power_notice_en_out <= 1'b0;
    end else if (feat_set_in && feat_sel_in == `WSR_FEAT_POWER_IND) begin
      power_notice_en_out <= 1'b1;
    end else if (feat_clr_in && feat_sel_in == `WSR_FEAT_POWER_IND) begin
      power_notice_en_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      link_quality_value_ff <= 8'h00;
    end else if (lq_valid_in) begin
      link_quality_value_ff <= link_quality_value_in;
    end
  end

  // ----------------------------------------------------------------
  // Response formatting
  // ----------------------------------------------------------------
  // Charging is meaningless without a rechargeable supply, so masked
  assign charge_state_bitmap = {6'h0,
    ctrl_ff[`WSR_CTRL_CHG] & ctrl_ff[`WSR_CTRL_RECH],
    ctrl_ff[`WSR_CTRL_RECH]};

  always_comb begin
    resp_len = 7'h00;
    case (setup_in.index[2:0])
      SEL_STD: resp_len = `WSR_LEN_STD;
      SEL_FEAT: resp_len = `WSR_LEN_FEAT;
      SEL_CHAN: resp_len = `WSR_LEN_CHAN;
      SEL_TXP: resp_len = `WSR_LEN_TXP;
      SEL_PWR: resp_len = `WSR_LEN_PWR;
      SEL_HOST: resp_len = `WSR_ID_BYTES + name_len_ff;
      default: resp_len = 7'h00;
    endcase
  end

  always_comb begin
    nxt_byte = 8'h00;
    case (sel_ff)
      SEL_STD: begin
        if (idx_ff == 7'h0) begin
          nxt_byte = {5'h0, battery_lvl, ctrl_ff[`WSR_CTRL_WAKE],
                      ctrl_ff[`WSR_CTRL_SELF]};
        end
      end
      SEL_FEAT: begin
        nxt_byte[`WSR_FEAT_PN_BIT] = power_notice_en_out;
      end
      SEL_CHAN: nxt_byte = link_quality_value_ff;
      SEL_TXP: begin
        if (idx_ff == 7'h0) begin
          nxt_byte = notice_tx_power_steps_ff;
        end
      end
      SEL_PWR: begin
        case (idx_ff[2:0])
          3'h0: nxt_byte = available_power_percent_ff;
          3'h1: nxt_byte = remaining_run_time_ff[7:0];
          3'h2: nxt_byte = remaining_run_time_ff[15:8];
          3'h3: nxt_byte = warning_power_percent_ff;
          3'h4: nxt_byte = critical_power_percent_ff;
          3'h5: nxt_byte = charge_state_bitmap;
          default: nxt_byte = 8'h00;
        endcase
      end
      // Key occupies store bytes 0..15, the name follows it directly
      SEL_HOST: nxt_byte = store_byte;
      default: nxt_byte = 8'h00;
    endcase
  end

  // Host relies on type 80H and wValue zero; anything else is refused
  assign req_legal = (setup_in.req_type == `WSR_REQ_TYPE_IN) &&
                     (setup_in.request == `WSR_GET_STATUS) &&
                     (setup_in.value == 16'h0000) &&
                     (setup_in.index[15:3] == 13'h0) &&
                     (setup_in.index[2:0] != SEL_RSV3) &&
                     (setup_in.index[2:0] != SEL_RSV4);

  // ----------------------------------------------------------------
  // Data stage sequencer
  // ----------------------------------------------------------------
  // Setups arriving while a data stage runs are ignored
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_ff <= ST_IDLE;
      sel_ff <= SEL_STD;
      cnt_ff <= 7'h00;
      idx_ff <= 7'h00;
      pos_ff <= 7'h00;
      rsp_valid_out <= 1'b0;
      rsp_byte_out <= 8'h00;
      rsp_last_out <= 1'b0;
      stall_out <= 1'b0;
    end else begin
      stall_out <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (setup_valid_in && req_legal) begin
            sel_ff <= wsr_sel_t'(setup_in.index[2:0]);
            cnt_ff <= (setup_in.length < {9'h0, resp_len}) ?
                      setup_in.length[6:0] : resp_len;
            idx_ff <= 7'h00;
            state_ff <= ST_SEND;
          end else if (setup_valid_in) begin
            stall_out <= 1'b1;
          end
        end
        ST_SEND: begin
          if (!rsp_valid_out || rsp_ready_in) begin
            if (idx_ff < cnt_ff) begin
              rsp_valid_out <= 1'b1;
              rsp_byte_out <= nxt_byte;
              rsp_last_out <= (idx_ff == cnt_ff - 7'h1);
              pos_ff <= idx_ff;
              idx_ff <= idx_ff + 7'h1;
            end else begin
              rsp_valid_out <= 1'b0;
              rsp_last_out <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_std_byte_zero: assert property (
    rsp_valid_out && sel_ff == SEL_STD |->
      rsp_byte_out[7:3] == 5'h0 && (pos_ff != 7'h0 || rsp_byte_out[0] ==
      ctrl_ff[`WSR_CTRL_SELF]) && (pos_ff == 7'h0 || rsp_byte_out == 8'h0))
    else $error("standard status byte malformed");

  a_self_pw_reset: assert property (
    $past(!resetn_in) |-> ctrl_ff[`WSR_CTRL_SELF])
    else $error("self powered not one after reset");

  a_batt_in_status: assert property (
    rsp_valid_out && $rose(rsp_valid_out) && sel_ff == SEL_STD &&
    pos_ff == 7'h0 && $stable(battery_lvl) |->
      rsp_byte_out[2] == battery_lvl)
    else $error("battery bit does not follow supply");

  a_feat_byte_form: assert property (
    rsp_valid_out && $rose(rsp_valid_out) && sel_ff == SEL_FEAT &&
    $stable(power_notice_en_out) |->
      rsp_byte_out == {3'h0, power_notice_en_out, 4'h0})
    else $error("feature byte malformed");

  a_pn_reset_clear: assert property (
    $past(!resetn_in) |-> !power_notice_en_out ##1 1)
    else $error("power notice not cleared by reset");

  a_pn_set_clear: assert property (
    feat_sel_in == `WSR_FEAT_POWER_IND && (feat_set_in || feat_clr_in) |=>
      power_notice_en_out == $past(feat_set_in))
    else $error("power notice flag wrong after request");

  a_txp_rsv_zero: assert property (
    rsp_valid_out && sel_ff == SEL_TXP && pos_ff == 7'h1 |->
      rsp_byte_out == 8'h00)
    else $error("reserved transmit power byte not zero");

  a_charge_map: assert property (
    rsp_valid_out && sel_ff == SEL_PWR && pos_ff == 7'h5 |->
      rsp_byte_out[7:2] == 6'h0 && (!rsp_byte_out[1] || rsp_byte_out[0]))
    else $error("charge bitmap malformed");

  a_host_len_max: assert property (
    state_ff == ST_SEND && sel_ff == SEL_HOST |-> cnt_ff <= 7'h50)
    else $error("other host reply too long");

  a_bad_sel_stall: assert property (
    state_ff == ST_IDLE && setup_valid_in && !req_legal |=>
      stall_out ##1 !stall_out && state_ff == ST_IDLE)
    else $error("reserved selector not stalled");

  c_std_done: cover property (rsp_last_out && sel_ff == SEL_STD);
  c_pwr_done: cover property (rsp_last_out && sel_ff == SEL_PWR);
  c_host_name: cover property (rsp_valid_out && pos_ff == 7'h10);
  c_stall_seen: cover property (stall_out);

endmodule : wsr_responder

// *** bench/wsr_host_model.sv ***
// Host controller model that issues status requests and takes the data stage
module wsr_host_model
  import wsr_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Setup stage
  output logic setup_valid_out,
  output wsr_setup_t setup_out,
  // Data stage
  output logic rsp_ready_out,
  input wire logic rsp_valid_in,
  input wire logic [7:0] rsp_byte_in,
  input wire logic rsp_last_in,
  input wire logic stall_in
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] rx [0:127];
  int n_rx;
  logic got_stall;

  initial begin
    setup_valid_out = 1'b0;
    setup_out = '0;
    rsp_ready_out = 1'b0;
    n_rx = 0;
    got_stall = 1'b0;
  end

  // ----------------------------------------------------------------
  // One request; a slow host accepts only on every other cycle
  // ----------------------------------------------------------------
  task automatic host_req(input logic [7:0] rtype, input logic [15:0] idx,
                          input logic [15:0] len, input bit slow);
    bit done;
    done = 1'b0;
    n_rx = 0;
    got_stall = 1'b0;
    @(posedge clk_in);
    setup_valid_out <= 1'b1;
    setup_out <= {rtype, 8'h00, 16'h0000, idx, len};
    rsp_ready_out <= !slow;
    @(posedge clk_in);
    setup_valid_out <= 1'b0;
    // Bounded wait: a zero-length stage ends only by this count
    for (int i = 0; i < 200 && !done; i++) begin
      @(posedge clk_in);
      if (stall_in) begin
        got_stall = 1'b1;
        done = 1'b1;
      end
      if (rsp_valid_in && rsp_ready_out) begin
        rx[n_rx] = rsp_byte_in;
        n_rx++;
        done = rsp_last_in;
      end
      if (!done) begin
        rsp_ready_out <= slow ? !rsp_ready_out : 1'b1;
      end
    end
    rsp_ready_out <= 1'b0;
    @(posedge clk_in);
  endtask : host_req
endmodule : wsr_host_model

// *** bench/test_wireless_status_responder.sv ***
// Self-checking bench for the wireless status responder
`include "wsr_map.svh"
module test_wireless_status_responder
  import wsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, resetn, pready, pslverr, setup_valid, rsp_ready, rsp_valid;
  logic rsp_last, stall, feat_set, feat_clr, pn_en, lq_valid, bat_pin, err;
  logic [31:0] prdata, rd;
  logic [7:0] rsp_byte, feat_sel, lq_val;
  wsr_apb_req_t apb;
  wsr_setup_t setup;
  int err_total = 0;
  int n_checks = 0;

  wsr_responder u_dut (.clk_in(clk), .resetn_in(resetn), .apb_in(apb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .setup_valid_in(setup_valid), .setup_in(setup),
    .rsp_ready_in(rsp_ready), .rsp_valid_out(rsp_valid),
    .rsp_byte_out(rsp_byte), .rsp_last_out(rsp_last), .stall_out(stall),
    .feat_set_in(feat_set), .feat_clr_in(feat_clr), .feat_sel_in(feat_sel),
    .power_notice_en_out(pn_en), .lq_valid_in(lq_valid),
    .link_quality_value_in(lq_val), .battery_pin_in(bat_pin));

  wsr_host_model u_host (.clk_in(clk), .setup_valid_out(setup_valid),
    .setup_out(setup), .rsp_ready_out(rsp_ready), .rsp_valid_in(rsp_valid),
    .rsp_byte_in(rsp_byte), .rsp_last_in(rsp_last), .stall_in(stall));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input int k, input logic [7:0] exp);
    chk({24'h0, u_host.rx[k]}, {24'h0, exp});
  endtask : chkb

  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic apb_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : apb_xfer

  task automatic req(input logic [15:0] idx, input logic [15:0] len,
                     input int n, input bit slow);
    u_host.host_req(8'h80, idx, len, slow);
    chk(32'(u_host.n_rx), 32'(n));
  endtask : req

  task automatic feat(input logic s, input logic c);
    @(posedge clk);
    feat_set <= s;
    feat_clr <= c;
    @(posedge clk);
    feat_set <= 1'b0;
    feat_clr <= 1'b0;
    @(posedge clk);
  endtask : feat

  function automatic logic [7:0] bval(input int k);
    return 8'(8'h80 + k);
  endfunction : bval

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb_xfer(1'b0, `WSR_REG_CTRL, 32'h0);
    chk(rd, 32'h2);
    apb_xfer(1'b0, `WSR_REG_TXPWR, 32'h0);
    chk(rd, 32'h0);
    apb_xfer(1'b0, 8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({31'h0, pn_en}, 32'h0);
  endtask : t_regs

  task automatic t_std();
    bat_pin <= 1'b1;
    repeat (8) @(posedge clk);
    apb_xfer(1'b1, `WSR_REG_CTRL, 32'h3);
    req(16'h0000, 16'h0002, 2, 1'b0);
    chkb(0, 8'h07);
    chkb(1, 8'h00);
    feat(1'b1, 1'b0);
    feat(1'b0, 1'b1);
    req(16'h0000, 16'h00ff, 2, 1'b1);
    chkb(0, 8'h07);
    bat_pin <= 1'b0;
    repeat (8) @(posedge clk);
    req(16'h0000, 16'h0002, 2, 1'b0);
    chkb(0, 8'h03);
    req(16'h0000, 16'h0000, 0, 1'b0);
  endtask : t_std

  task automatic t_feat();
    feat_sel <= 8'h03;
    feat(1'b1, 1'b0);
    chk({31'h0, pn_en}, 32'h0);
    feat_sel <= 8'h04;
    feat(1'b1, 1'b0);
    chk({31'h0, pn_en}, 32'h1);
    req(16'h0001, 16'h0008, 1, 1'b0);
    chkb(0, 8'h10);
    feat(1'b0, 1'b1);
    chk({31'h0, pn_en}, 32'h0);
    req(16'h0001, 16'h0001, 1, 1'b0);
    chkb(0, 8'h00);
  endtask : t_feat

  task automatic t_chan_txp();
    lq_val <= 8'h5a;
    lq_valid <= 1'b1;
    @(posedge clk);
    lq_val <= 8'ha5;
    @(posedge clk);
    lq_valid <= 1'b0;
    req(16'h0002, 16'h0004, 1, 1'b0);
    chkb(0, 8'ha5);
    apb_xfer(1'b1, `WSR_REG_TXPWR, 32'h07);
    req(16'h0005, 16'h0002, 2, 1'b1);
    chkb(0, 8'h07);
    chkb(1, 8'h00);
  endtask : t_chan_txp

  task automatic t_pwr();
    logic [7:0] e [6] = '{8'h32, 8'hef, 8'hbe, 8'h14, 8'h0a, 8'h03};
    apb_xfer(1'b1, `WSR_REG_PWR, 32'h000a1432);
    apb_xfer(1'b1, `WSR_REG_RUNTIME, 32'h0000beef);
    apb_xfer(1'b1, `WSR_REG_CTRL, 32'h0e);
    req(16'h0006, 16'h0006, 6, 1'b1);
    for (int k = 0; k < 6; k++) chkb(k, e[k]);
    apb_xfer(1'b1, `WSR_REG_CTRL, 32'h0a);
    req(16'h0006, 16'h0010, 6, 1'b0);
    chkb(5, 8'h00);
    req(16'h0006, 16'h0003, 3, 1'b0);
    chkb(2, 8'hbe);
  endtask : t_pwr

  task automatic t_host();
    for (int w = 0; w < 20; w++) begin
      apb_xfer(1'b1, 8'(`WSR_STORE_BASE + 4 * w),
               {bval(4*w+3), bval(4*w+2), bval(4*w+1), bval(4*w)});
    end
    apb_xfer(1'b1, `WSR_REG_NAMELEN, 32'h7f);
    apb_xfer(1'b0, `WSR_REG_NAMELEN, 32'h0);
    chk(rd, 32'h40);
    req(16'h0007, 16'hffff, 80, 1'b0);
    for (int k = 0; k < 80; k++) chkb(k, bval(k));
    apb_xfer(1'b1, `WSR_REG_NAMELEN, 32'h0);
    req(16'h0007, 16'h00ff, 16, 1'b1);
    chkb(15, bval(15));
  endtask : t_host

  task automatic t_refuse();
    logic [15:0] bad [3] = '{16'h0003, 16'h0004, 16'h0008};
    foreach (bad[i]) begin
      req(bad[i], 16'h0002, 0, 1'b0);
      chk({31'h0, u_host.got_stall}, 32'h1);
    end
    u_host.host_req(8'h00, 16'h0000, 16'h0002, 1'b0);
    chk({31'h0, u_host.got_stall}, 32'h1);
  endtask : t_refuse

  task automatic t_reset_mid();
    feat(1'b1, 1'b0);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, pn_en}, 32'h0);
    req(16'h0001, 16'h0001, 1, 1'b0);
    chkb(0, 8'h00);
  endtask : t_reset_mid

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    apb = '0;
    bat_pin = 1'b0;
    feat_set = 1'b0;
    feat_clr = 1'b0;
    feat_sel = 8'h04;
    lq_valid = 1'b0;
    lq_val = 8'h00;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_std();
    t_feat();
    t_chan_txp();
    t_pwr();
    t_host();
    t_refuse();
    t_reset_mid();
    wrap_up();
  end

  // The whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule : test_wireless_status_responder
